/* include/mtmon_pkg.sv */
// Constants, types and register indices of the temperature monitor
package mtmon_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int FREEZE_MS = 25;
  localparam int FREEZE_CYCLES = CLK_HZ / 1000 * FREEZE_MS;
  localparam int TMR_W = 20;

  localparam int NUM_CH = 7;
  localparam logic [2:0] CH_REMOTE1 = 3'h0;
  localparam logic [2:0] CH_FIRST_OTHER = 3'h1;
  localparam logic [2:0] CH_LAST = 3'h6;
  localparam logic [2:0] CH_THERM1 = 3'h4;
  localparam logic [2:0] CH_THERM2 = 3'h5;
  localparam logic [2:0] CH_THERM3 = 3'h6;

  localparam logic [6:0] ARA_ADDR = 7'h0c;

  localparam logic [7:0] REG_TEMP_BASE = 8'h01;
  localparam logic [7:0] REG_TEMP_EXT = 8'h09;
  localparam logic [7:0] REG_ALERT_BASE = 8'h10;
  localparam logic [7:0] REG_OVERTEMP_ALARM_N_BASE = 8'h20;
  localparam logic [7:0] REG_CFG1 = 8'h41;
  localparam logic [7:0] REG_CFG2 = 8'h42;
  localparam logic [7:0] REG_CFG3 = 8'h43;
  localparam logic [7:0] REG_STAT_ALERT = 8'h44;
  localparam logic [7:0] REG_STAT_OVERTEMP_ALARM_N = 8'h45;

  localparam int CFG1_STANDBY = 7;
  localparam int CFG1_SOFT_RST = 6;
  localparam int CFG1_TMO_DIS = 5;
  localparam int CFG1_FAST_CH1 = 4;
  localparam logic [7:0] CFG_POR = 8'h00;
  localparam logic [7:0] CMD_POR = 8'h00;
  localparam logic [7:0] TEMP_POR = 8'h00;
  localparam logic [7:0] ALERT_LIM_POR = 8'h7f;
  localparam logic [7:0] OVERTEMP_ALARM_N_LIM_POR = 8'h7f;
  localparam logic [7:0] OVERTEMP_ALARM_N_BITS = 8'h39;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic done;
    logic [10:0] code;
  } mtmon_adc_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [2:0] chan;
  } mtmon_conv_t;

  typedef enum {
    MT_IDLE, MT_ADDR, MT_CMD, MT_WDAT, MT_ACK, MT_RDAT, MT_MACK, MT_SKIP
  } mtmon_bus_st_t;
endpackage

/* logic/mtmon_core.sv */
// Temperature monitor control: conversion sequencer, alarms and SMBus slave
// Operation
// - Overtemperature output pulled low when channel 1, 4, 5 or 6 exceeds its limit.
// - Alert output pulled low when any channel exceeds its own alert limit.
// - Default order: remote 1-3, local, thermistors 1-3, each stored separately.
// - Fast mode bit interleaves remote 1 with every other channel in turn.
// - Standby bit stops the converter; no conversions are started.
// - Standby keeps all registers and the slave port working.
// - Bus timeout only runs after a start condition was seen.
// - Standby during a conversion aborts it; stored results stay unchanged.
// - All registers are 8 bits, behind one slave address.
// - Only write byte, read byte, send byte and receive byte are served.
// - Receive byte returns the register chosen by the last command byte.
// - Remote 1 yields an 11-bit result, 0.125 degree per step.
// - Other channels yield 8-bit results, one degree per step.
// - Upper eight result bits sit in each channel's main register.
// - Thermistor results are a reference-voltage fraction, stored raw.
// - Clock held low past the timeout resets the slave protocol.
// - Reading the extended byte freezes remote 1 high byte until read or timeout.
// - Overtemperature channels 1, 4, 5, 6 are remote 1 and thermistors 1-3.
// - Alert releases on status read or alert response; reasserts if fault persists.
module mtmon_core
  import mtmon_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a, // Arbitrary value
  parameter int TIMEOUT_CNT = TIMEOUT_CYCLES,
  parameter int FREEZE_CNT = FREEZE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic overtemp_alarm_n_out,
  output logic overtemp_alarm_n_oe,
  output logic alert_n_out,
  output logic alert_n_oe,
  input wire mtmon_adc_t adc_result,
  output mtmon_conv_t conv_req
);
  logic [7:0] temp [NUM_CH];
  logic [7:0] alert_lim [NUM_CH];
  logic [7:0] overtemp_alarm_n_lim [4];
  logic [2:0] temp_ext;
  logic [7:0] cfg1, cfg2, cfg3;
  logic [6:0] alert_stat;
  logic [7:0] overtemp_alarm_n_stat;
  logic alert_latch, freeze;
  logic [TMR_W-1:0] freeze_cnt, tmo_cnt;

  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  mtmon_bus_st_t state, after_ack;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, tx, cmd_reg, wr_data;
  logic is_ara, wr_stb, rd_stb, ara_done;

  logic busy, fast_phase;
  logic [2:0] cur_ch, seq_idx, other_ch;

  function automatic logic [2:0] alert_pos(input logic [2:0] ch);
    case (ch)
      3'h0: alert_pos = 3'h5;
      3'h1: alert_pos = 3'h4;
      3'h2: alert_pos = 3'h3;
      3'h3: alert_pos = 3'h6;
      3'h4: alert_pos = 3'h2;
      3'h5: alert_pos = 3'h1;
      default: alert_pos = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] overtemp_alarm_n_pos(input logic [2:0] ch);
    case (ch)
      CH_THERM1: overtemp_alarm_n_pos = 3'h5;
      CH_THERM2: overtemp_alarm_n_pos = 3'h4;
      CH_THERM3: overtemp_alarm_n_pos = 3'h3;
      default: overtemp_alarm_n_pos = 3'h0;
    endcase
  endfunction

  function automatic logic [1:0] overtemp_alarm_n_slot(input logic [2:0] ch);
    overtemp_alarm_n_slot = (ch == CH_REMOTE1) ? 2'h0 : 2'(ch - CH_THERM1 + 3'h1);
  endfunction

  // Bus pins pass two flops; the third stage only serves edge detection
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3f;
    end else if (clk_en) begin
      {scl_m, scl_s, scl_q} <= {serial_clock_line, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {serial_data_line_in, sda_m, sda_s};
    end
  end

  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
  wire byte_done = scl_fall && (bit_cnt == BITS_PER_BYTE);
  wire standby = cfg1[CFG1_STANDBY];
  wire timeout_hit = (tmo_cnt >= TMR_W'(TIMEOUT_CNT));
  wire [2:0] next_ch = cfg1[CFG1_FAST_CH1] ? (fast_phase ? other_ch : CH_REMOTE1) : seq_idx;
  wire res_done = busy & adc_result.done & ~standby;
  wire [7:0] res_hi = adc_result.code[10:3];
  wire has_overtemp_alarm_n = (cur_ch == CH_REMOTE1) || (cur_ch >= CH_THERM1);
  wire [7:0] cmd_temp = cmd_reg - REG_TEMP_BASE;
  wire [7:0] cmd_alert = cmd_reg - REG_ALERT_BASE;
  wire [7:0] cmd_overtemp_alarm_n = cmd_reg - REG_OVERTEMP_ALARM_N_BASE;
  wire in_temp = cmd_temp < 8'(NUM_CH);
  wire in_alert = cmd_alert < 8'(NUM_CH);
  wire in_overtemp_alarm_n = cmd_overtemp_alarm_n < 8'h4;
  wire wr_soft_rst = wr_stb && cmd_reg == REG_CFG1 && wr_data[CFG1_SOFT_RST];
  wire stat_read = rd_stb && cmd_reg == REG_STAT_ALERT;
  wire rd_ch1_hi = rd_stb && cmd_reg == REG_TEMP_BASE;

  // Single address serves every register; unmapped indices read zero
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (in_temp) rd_val = temp[cmd_temp[2:0]];
    else if (in_alert) rd_val = alert_lim[cmd_alert[2:0]];
    else if (in_overtemp_alarm_n) rd_val = overtemp_alarm_n_lim[cmd_overtemp_alarm_n[1:0]];
    else if (cmd_reg == REG_TEMP_EXT) rd_val = {temp_ext, 5'h00};
    else if (cmd_reg == REG_CFG1) rd_val = cfg1;
    else if (cmd_reg == REG_CFG2) rd_val = cfg2;
    else if (cmd_reg == REG_CFG3) rd_val = cfg3;
    else if (cmd_reg == REG_STAT_ALERT) rd_val = {1'b0, alert_stat};
    else if (cmd_reg == REG_STAT_OVERTEMP_ALARM_N) rd_val = overtemp_alarm_n_stat;
  end

  // Timeout counts only inside a frame, so an idle bus never trips it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmo_cnt <= '0;
    end else if (clk_en) begin
      if (state == MT_IDLE || scl_s || cfg1[CFG1_TMO_DIS] || timeout_hit) tmo_cnt <= '0;
      else tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  // SMBus slave protocol engine
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= MT_IDLE;
      after_ack <= MT_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      cmd_reg <= CMD_POR;
      wr_data <= 8'h00;
      is_ara <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      ara_done <= 1'b0;
      serial_data_line_oe <= 1'b0;
    end else if (clk_en) begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      ara_done <= 1'b0;
      if (start_det) begin
        state <= MT_ADDR;
        bit_cnt <= 4'h0;
        is_ara <= 1'b0;
        serial_data_line_oe <= 1'b0;
      end else if (stop_det || timeout_hit) begin
        state <= MT_IDLE;
        serial_data_line_oe <= 1'b0;
      end else begin
        case (state)
          MT_ADDR, MT_CMD, MT_WDAT: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
              bit_cnt <= 4'h0;
              serial_data_line_oe <= 1'b1;
              state <= MT_ACK;
              if (state == MT_ADDR) begin
                if (shreg[7:1] == SLAVE_ADDR) begin
                  after_ack <= shreg[0] ? MT_RDAT : MT_CMD;
                  tx <= rd_val;
                  rd_stb <= shreg[0];
                end else if (shreg[7:1] == ARA_ADDR && shreg[0] && alert_latch) begin
                  after_ack <= MT_RDAT;
                  tx <= {SLAVE_ADDR, 1'b0};
                  is_ara <= 1'b1;
                end else begin
                  serial_data_line_oe <= 1'b0;
                  state <= MT_SKIP;
                end
              end else if (state == MT_CMD) begin
                cmd_reg <= shreg;
                after_ack <= MT_WDAT;
              end else begin
                wr_data <= shreg;
                wr_stb <= 1'b1;
                after_ack <= MT_SKIP;
              end
            end
          end
          MT_ACK: begin
            if (scl_fall) begin
              state <= after_ack;
              bit_cnt <= (after_ack == MT_RDAT) ? 4'h1 : 4'h0;
              serial_data_line_oe <= (after_ack == MT_RDAT) ? ~tx[7] : 1'b0;
            end
          end
          MT_RDAT: begin
            if (byte_done) begin
              serial_data_line_oe <= 1'b0;
              state <= MT_MACK;
            end else if (scl_fall) begin
              serial_data_line_oe <= ~tx[6];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          MT_MACK: begin
            if (scl_rise) begin
              ara_done <= is_ara;
              if (sda_s || is_ara) begin
                state <= MT_SKIP;
              end else begin
                tx <= rd_val;
                rd_stb <= 1'b1;
                after_ack <= MT_RDAT;
                state <= MT_ACK;
              end
            end
          end
          MT_SKIP, MT_IDLE: state <= state;
          default: state <= MT_IDLE;
        endcase
      end
    end
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      fast_phase <= 1'b0;
      cur_ch <= CH_REMOTE1;
      seq_idx <= CH_REMOTE1;
      other_ch <= CH_FIRST_OTHER;
      conv_req <= '0;
    end else if (clk_en) begin
      conv_req <= '0;
      if (standby) begin
        conv_req.abort <= busy;
        busy <= 1'b0;
      end else if (!busy) begin
        conv_req.start <= 1'b1;
        conv_req.chan <= next_ch;
        cur_ch <= next_ch;
        busy <= 1'b1;
        seq_idx <= (seq_idx == CH_LAST) ? CH_REMOTE1 : seq_idx + 3'h1;
        fast_phase <= ~fast_phase;
        if (fast_phase) other_ch <= (other_ch == CH_LAST) ? CH_FIRST_OTHER : other_ch + 3'h1;
      end else if (adc_result.done) begin
        busy <= 1'b0;
      end
    end
  end

  // Register file, result storage and alarm flags
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) temp[i] <= TEMP_POR;
      for (int i = 0; i < NUM_CH; i++) alert_lim[i] <= ALERT_LIM_POR;
      for (int i = 0; i < 4; i++) overtemp_alarm_n_lim[i] <= OVERTEMP_ALARM_N_LIM_POR;
      temp_ext <= 3'h0;
      {cfg1, cfg2, cfg3} <= {CFG_POR, CFG_POR, CFG_POR};
      alert_stat <= 7'h00;
      overtemp_alarm_n_stat <= 8'h00;
      alert_latch <= 1'b0;
      freeze <= 1'b0;
      freeze_cnt <= '0;
    end else if (clk_en) begin
      if (wr_soft_rst) begin
        for (int i = 0; i < NUM_CH; i++) temp[i] <= TEMP_POR;
        for (int i = 0; i < NUM_CH; i++) alert_lim[i] <= ALERT_LIM_POR;
        for (int i = 0; i < 4; i++) overtemp_alarm_n_lim[i] <= OVERTEMP_ALARM_N_LIM_POR;
        temp_ext <= 3'h0;
        {cfg1, cfg2, cfg3} <= {CFG_POR, CFG_POR, CFG_POR};
        alert_stat <= 7'h00;
        overtemp_alarm_n_stat <= 8'h00;
        alert_latch <= 1'b0;
        freeze <= 1'b0;
      end else begin
        if (wr_stb) begin
          if (in_alert) alert_lim[cmd_alert[2:0]] <= wr_data;
          if (in_overtemp_alarm_n) overtemp_alarm_n_lim[cmd_overtemp_alarm_n[1:0]] <= wr_data;
          if (cmd_reg == REG_CFG1) cfg1 <= wr_data;
          if (cmd_reg == REG_CFG2) cfg2 <= wr_data;
          if (cmd_reg == REG_CFG3) cfg3 <= wr_data;
        end
        // Freeze guards the high byte so a split read stays coherent
        if (rd_stb && cmd_reg == REG_TEMP_EXT) begin
          freeze <= 1'b1;
          freeze_cnt <= '0;
        end else if (rd_ch1_hi || freeze_cnt >= TMR_W'(FREEZE_CNT)) begin
          freeze <= 1'b0;
        end else if (freeze) begin
          freeze_cnt <= freeze_cnt + 1'b1;
        end
        if (stat_read) alert_stat <= 7'h00;
        if (stat_read || ara_done) alert_latch <= 1'b0;
        // Results land only on completion; a set beats a same-cycle clear
        if (res_done) begin
          if (cur_ch != CH_REMOTE1 || !freeze) temp[cur_ch] <= res_hi;
          if (cur_ch == CH_REMOTE1 && !freeze) temp_ext <= adc_result.code[2:0];
          if (res_hi > alert_lim[cur_ch]) begin
            alert_stat[alert_pos(cur_ch)] <= 1'b1;
            if (!cfg2[alert_pos(cur_ch)]) alert_latch <= 1'b1;
          end
          if (has_overtemp_alarm_n) overtemp_alarm_n_stat[overtemp_alarm_n_pos(cur_ch)] <= res_hi > overtemp_alarm_n_lim[overtemp_alarm_n_slot(cur_ch)];
        end
      end
    end
  end

  assign serial_data_line_out = 1'b0;
  assign overtemp_alarm_n_out = 1'b0;
  assign alert_n_out = 1'b0;
  assign overtemp_alarm_n_oe = |(overtemp_alarm_n_stat & ~cfg3 & OVERTEMP_ALARM_N_BITS);
  assign alert_n_oe = alert_latch;
endmodule // mtmon_core

/* verif/mtmon_monitor.sv */
// Port assertions for the temperature monitor core
module mtmon_monitor
  import mtmon_pkg::*;
#(
  parameter int TIMEOUT_CNT = 200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic overtemp_alarm_n_out,
  input wire logic overtemp_alarm_n_oe,
  input wire logic alert_n_out,
  input wire logic alert_n_oe,
  input wire mtmon_adc_t adc_result,
  input wire mtmon_conv_t conv_req
);
  logic busy;
  int low_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      low_cnt <= 0;
    end else begin
      if (clk_en && conv_req.start) busy <= 1'b1;
      else if (clk_en && (adc_result.done || conv_req.abort)) busy <= 1'b0;
      low_cnt <= serial_clock_line ? 0 : low_cnt + 1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_open_drain;
    !serial_data_line_out && !overtemp_alarm_n_out && !alert_n_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain level not low");
  property p_start_pulse;
    conv_req.start |=> !conv_req.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_one_conv;
    conv_req.start |-> !busy;
  endproperty
  a_one_conv: assert property (p_one_conv) else $error("start while converting");
  property p_next_start;
    busy && adc_result.done && clk_en |-> ##2 conv_req.start;
  endproperty
  a_next_start: assert property (p_next_start) else $error("no start after done");
  property p_abort_busy;
    conv_req.abort |-> busy;
  endproperty
  a_abort_busy: assert property (p_abort_busy) else $error("abort without conversion");
  property p_abort_quiet;
    conv_req.abort |=> !conv_req.start [*8];
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("start after standby abort");
  property p_timeout;
    low_cnt > TIMEOUT_CNT + 10 |-> !serial_data_line_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("data held past clock timeout");
  property p_bit_hold;
    $rose(serial_data_line_oe) |=> serial_data_line_oe [*6];
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("driven bit too short");
  property p_alert_cause;
    $rose(alert_n_oe) |-> $past(adc_result.done) || $past(adc_result.done, 2)
      || $past(adc_result.done, 3);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without conversion");
endmodule // mtmon_monitor

bind mtmon_core mtmon_monitor #(.TIMEOUT_CNT(TIMEOUT_CNT)) i_mtmon_monitor (
  .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .serial_clock_line(serial_clock_line),
  .serial_data_line_in(serial_data_line_in), .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe(serial_data_line_oe), .overtemp_alarm_n_out(overtemp_alarm_n_out),
  .overtemp_alarm_n_oe(overtemp_alarm_n_oe), .alert_n_out(alert_n_out),
  .alert_n_oe(alert_n_oe), .adc_result(adc_result), .conv_req(conv_req));

/* verif/mtmon_host.sv */
// SMBus host model: drives the clock, pulls data low, idles with clock high
module mtmon_host (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Data moves one cycle after the clock falls, never beside it
  task automatic bit_io(input logic b, output logic r);
    cyc(1);
    sda_oe = !b;
    cyc(3);
    scl = 1'b1;
    cyc(4);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start_c();
    cyc(1);
    sda_oe = 1'b0;
    cyc(3);
    scl = 1'b1;
    cyc(4);
    sda_oe = 1'b1;
    cyc(4);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    cyc(1);
    sda_oe = 1'b1;
    cyc(3);
    scl = 1'b1;
    cyc(4);
    sda_oe = 1'b0;
    cyc(4);
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bit_io(tx[i], rx[i]);
  endtask
endmodule // mtmon_host

/* verif/tb_top.sv */
// Self-checking bench for the temperature monitor core
module tb_top
  import mtmon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 200;
  localparam int CONV = 300;
  localparam logic [6:0] ADDR = 7'h2a;
  logic sys_clk, rst, scl, host_oe, serial_data_line_out, serial_data_line_oe;
  logic overtemp_alarm_n_out, overtemp_alarm_n_oe, alert_n_out, alert_n_oe;
  mtmon_adc_t adc_result;
  mtmon_conv_t conv_req;
  logic [10:0] codes[7];
  logic [2:0] starts[$];
  logic [2:0] ch;
  int left, n_abort, n_mismatch, cmp_count;
  wire sda;
  assign sda = !(host_oe || serial_data_line_oe);
  mtmon_core #(.SLAVE_ADDR(ADDR), .TIMEOUT_CNT(TMO), .FREEZE_CNT(TMO)) i_mtmon_core (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .serial_clock_line(scl),
    .serial_data_line_in(sda), .serial_data_line_out(serial_data_line_out),
    .serial_data_line_oe(serial_data_line_oe), .overtemp_alarm_n_out(overtemp_alarm_n_out),
    .overtemp_alarm_n_oe(overtemp_alarm_n_oe), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .adc_result(adc_result), .conv_req(conv_req));
  mtmon_host i_mtmon_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_oe(host_oe));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Converter stand-in: fixed conversion time, abort drops the result
  always @(posedge sys_clk) begin
    adc_result.done <= (left == 1);
    adc_result.code <= codes[ch];
    if (conv_req.start === 1'b1) begin
      left <= CONV;
      ch <= conv_req.chan;
      starts.push_back(conv_req.chan);
    end else if (conv_req.abort === 1'b1) begin
      left <= 0;
      n_abort <= n_abort + 1;
    end else if (left > 0) left <= left - 1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic txn(input logic cp, input logic rp, input logic wp, input logic [7:0] cmd,
                     input logic [7:0] wd, output logic [7:0] rd);
    logic [8:0] rx;
    rd = 8'h00;
    i_mtmon_host.start_c();
    if (cp) begin
      i_mtmon_host.xfer({ADDR, 1'b0, 1'b1}, rx);
      chk("addr ack", 8'h00, {7'h0, rx[0]});
      i_mtmon_host.xfer({cmd, 1'b1}, rx);
      chk("cmd ack", 8'h00, {7'h0, rx[0]});
      if (wp) i_mtmon_host.xfer({wd, 1'b1}, rx);
      if (wp) chk("data ack", 8'h00, {7'h0, rx[0]});
      if (rp) i_mtmon_host.start_c();
    end
    if (rp) begin
      i_mtmon_host.xfer({ADDR, 1'b1, 1'b1}, rx);
      chk("read ack", 8'h00, {7'h0, rx[0]});
      i_mtmon_host.xfer(9'h1ff, rx);
      rd = rx[8:1];
    end
    i_mtmon_host.stop_c();
  endtask
  task automatic wreg(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    txn(1'b1, 1'b0, 1'b1, c, d, x);
  endtask
  task automatic rreg(input logic [7:0] c, output logic [7:0] d);
    txn(1'b1, 1'b1, 1'b0, c, 8'h00, d);
  endtask
  task automatic wait_n(input int n);
    starts.delete();
    for (int k = 0; k < 3000 && starts.size() < n; k++) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_seq();
    for (int k = 0; k < 3000 && starts.size() < 8; k++) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) chk("chan order", 8'(i % 7), {5'h0, starts[i]});
    $display("sequence test done");
  endtask
  task automatic t_regs();
    logic [7:0] d;
    wreg(REG_ALERT_BASE + 8'h02, 8'h5a);
    rreg(REG_ALERT_BASE + 8'h02, d);
    chk("limit readback", 8'h5a, d);
    rreg(REG_TEMP_EXT, d);
    chk("ext byte", 8'ha0, d);
    rreg(REG_TEMP_BASE, d);
    chk("remote1 high", 8'h40, d);
    rreg(REG_TEMP_BASE + 8'h04, d);
    chk("therm1 value", 8'h34, d);
    txn(1'b1, 1'b0, 1'b0, REG_TEMP_BASE + 8'h03, 8'h00, d);
    txn(1'b0, 1'b1, 1'b0, 8'h00, 8'h00, d);
    chk("receive byte", 8'h33, d);
    rreg(8'h7e, d);
    chk("unmapped", 8'h00, d);
    $display("register test done");
  endtask
  task automatic t_alarm();
    logic [7:0] d;
    wreg(REG_OVERTEMP_ALARM_N_BASE, 8'h3f);
    wait_n(8);
    chk("overtemp_alarm_n on", 8'h01, {7'h0, overtemp_alarm_n_oe});
    wreg(REG_OVERTEMP_ALARM_N_BASE, 8'h7f);
    wait_n(8);
    chk("overtemp_alarm_n off", 8'h00, {7'h0, overtemp_alarm_n_oe});
    wreg(REG_ALERT_BASE + 8'h04, 8'h33);
    wait_n(8);
    chk("alert on", 8'h01, {7'h0, alert_n_oe});
    wreg(REG_ALERT_BASE + 8'h04, 8'h7f);
    rreg(REG_STAT_ALERT, d);
    chk("alert status", 8'h04, d);
    wait_n(8);
    chk("alert off", 8'h00, {7'h0, alert_n_oe});
    $display("alarm test done");
  endtask
  task automatic t_fast();
    wreg(REG_CFG1, 8'h10);
    wait_n(8);
    for (int i = 0; i < 7; i++)
      chk("fast alt", 8'h01, {7'h0, (starts[i] == 3'h0) != (starts[i + 1] == 3'h0)});
    for (int i = 0; i < 6; i++)
      if (starts[i] != 3'h0)
        chk("fast next", (starts[i] == 3'h6) ? 8'h01 : 8'(starts[i] + 1), 8'(starts[i + 2]));
    wreg(REG_CFG1, 8'h00);
    $display("fast mode test done");
  endtask
  task automatic t_standby();
    logic [7:0] d;
    n_abort = 0;
    wreg(REG_CFG1, 8'h80);
    codes[4] = 11'h3b8;
    wait_n(3);
    chk("standby starts", 8'h00, 8'(starts.size()));
    chk("abort count", 8'h01, 8'(n_abort));
    rreg(REG_TEMP_BASE + 8'h04, d);
    chk("kept value", 8'h34, d);
    wreg(REG_CFG1, 8'h00);
    wait_n(8);
    rreg(REG_TEMP_BASE + 8'h04, d);
    chk("resumed value", 8'h77, d);
    $display("standby test done");
  endtask
  task automatic t_timeout();
    logic [7:0] a;
    logic r;
    a = {ADDR, 1'b0};
    i_mtmon_host.start_c();
    for (int i = 7; i >= 0; i--) i_mtmon_host.bit_io(a[i], r);
    i_mtmon_host.cyc(10);
    chk("ack held", 8'h01, {7'h0, serial_data_line_oe});
    i_mtmon_host.cyc(TMO + 30);
    chk("timeout release", 8'h00, {7'h0, serial_data_line_oe});
    i_mtmon_host.stop_c();
    rreg(REG_CFG1, a);
    chk("after timeout", 8'h00, a);
    $display("timeout test done");
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    adc_result = '0;
    {left, n_abort, n_mismatch, cmp_count} = '0;
    ch = 3'h0;
    codes[0] = 11'h205;
    for (int i = 1; i < 7; i++) codes[i] = {8'h30 + 8'(i), 3'h0};
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_seq();
    t_regs();
    t_alarm();
    t_fast();
    t_standby();
    t_timeout();
    end_sim();
  end
  // Whole run needs about 25000 cycles
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_mismatch++;
    end_sim();
  end
endmodule // tb_top
